// file: rtl/core_clk_rst_pkg.sv
// constants for the core clock and reset sequencer
package core_clk_rst_pkg;
  // ==========================================================
  // timing
  localparam int          REF_CLK_MHZ   = 50;
  localparam int          CORE_RST_CYC  = 4096;           // input-clock cycles of core reset hold
  localparam int          CORE_RST_MAX  = 4097;           // with one missed setup edge
  localparam int          MIN_PULSE_CYC = 4;              // later reset pulses, held by the board
  localparam int          PLL_SETUP_US  = 20;
  localparam int          PLL_SETUP_CYC = PLL_SETUP_US * REF_CLK_MHZ;
  localparam int          CNT_W         = 13;
  localparam int          SYNC_CYC      = 5;              // edges from first pin sample to count start
  // ==========================================================
  // ratio encodings
  localparam int          MULT_W        = 6;
  localparam int          SEL_W         = 2;
  localparam logic [1:0]  SEL_3TO1      = 2'h0;
  localparam logic [1:0]  SEL_16TO1     = 2'h1;
  localparam logic [1:0]  SEL_8TO1      = 2'h2;
  localparam logic [5:0]  MULT_3        = 6'h03;
  localparam logic [5:0]  MULT_8        = 6'h08;
  localparam logic [5:0]  MULT_16       = 6'h10;
  localparam logic [5:0]  MULT_DEFAULT  = MULT_3;
  localparam int          DIV_W         = 16;
  localparam int          ACC_W         = 17;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_COUNT = 3'b010,
    ST_RUN   = 3'b100
  } seq_state_e;
endpackage : core_clk_rst_pkg

// file: rtl/core_clock_reset_sequencer.sv
// start-up core clock ratio and core reset sequencer on the input clock
`timescale 1ns/1ps
module core_clock_reset_sequencer #(
  parameter int NPORTS = 4
) (
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  input  wire logic                       ext_rst_n,          // reset pin, asynchronous
  input  wire logic [1:0]                 ratio_select_pins,  // asynchronous straps
  input  wire logic                       pll_mult_wr,        // power_mgmt_control write strobe
  input  wire logic [5:0]                 pll_mult_in,
  input  wire logic [NPORTS*16-1:0]       serial_port_divider,
  output logic      [5:0]                 core_mult_r,        // multiplier to the PLL
  output logic                            core_rst_r,
  output logic                            io_default_r,
  output logic      [NPORTS-1:0]          sport_tick_r
);
  // ==========================================================
  // pin synchronisers: three stages, change taken when 2 and 3 agree, for the straps only while the pin is low
  logic [2:0] rst_sync_r;
  logic [2:0] rst_sync_nxt;
  logic [1:0] sel_s1_r, sel_s2_r, sel_s3_r;
  logic [1:0] sel_s1_nxt, sel_s2_nxt, sel_s3_nxt;
  logic       pin_low_r, pin_low_nxt;
  logic [1:0] sel_r, sel_nxt;

  // filtered pin level only moves when the last two stages agree
  always_comb begin
    rst_sync_nxt = {rst_sync_r[1:0], ext_rst_n};
    sel_s1_nxt   = ratio_select_pins;
    sel_s2_nxt   = sel_s1_r;
    sel_s3_nxt   = sel_s2_r;
    pin_low_nxt  = pin_low_r;
    if (rst_sync_r[1] == rst_sync_r[2]) begin
      pin_low_nxt = ~rst_sync_r[2];
    end
    sel_nxt = sel_r;
    if (pin_low_r && sel_s2_r == sel_s3_r) begin
      sel_nxt = sel_s3_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_sync_r <= 3'h0;
      sel_s1_r   <= 2'h0;
      sel_s2_r   <= 2'h0;
      sel_s3_r   <= 2'h0;
      pin_low_r  <= 1'b1;
      sel_r      <= 2'h0;
    end else if (clk_en) begin
      rst_sync_r <= rst_sync_nxt;
      sel_s1_r   <= sel_s1_nxt;
      sel_s2_r   <= sel_s2_nxt;
      sel_s3_r   <= sel_s3_nxt;
      pin_low_r  <= pin_low_nxt;
      sel_r      <= sel_nxt;
    end
  end

  // ==========================================================
  // core reset sequencer
  core_clk_rst_pkg::seq_state_e state_r, state_nxt;
  logic [12:0] cnt_r, cnt_nxt;
  logic        core_rst_nxt;
  logic        io_default_nxt;
  localparam logic [12:0] LAST_CNT = 13'(core_clk_rst_pkg::CORE_RST_CYC - 1);

  // pin reassertion wins in every state so the count always restarts
  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    core_rst_nxt   = core_rst_r;
    io_default_nxt = pin_low_r;
    case (state_r)
      core_clk_rst_pkg::ST_HOLD: begin
        cnt_nxt      = 13'h0000;
        core_rst_nxt = 1'b1;
        // the filter edges are already spent, so they count toward the hold
        // and the release does not land late by the synchroniser depth
        if (!pin_low_r) begin
          state_nxt = core_clk_rst_pkg::ST_COUNT;
          cnt_nxt   = 13'(core_clk_rst_pkg::SYNC_CYC);
        end
      end
      core_clk_rst_pkg::ST_COUNT: begin
        cnt_nxt = cnt_r + 13'h0001;
        if (cnt_r == LAST_CNT) begin
          state_nxt    = core_clk_rst_pkg::ST_RUN;
          core_rst_nxt = 1'b0;
        end
      end
      core_clk_rst_pkg::ST_RUN: begin
        core_rst_nxt = 1'b0;
      end
      default: begin
        state_nxt    = core_clk_rst_pkg::ST_HOLD;
        core_rst_nxt = 1'b1;
      end
    endcase
    if (pin_low_r) begin
      state_nxt    = core_clk_rst_pkg::ST_HOLD;
      cnt_nxt      = 13'h0000;
      core_rst_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r      <= core_clk_rst_pkg::ST_HOLD;
      cnt_r        <= 13'h0000;
      core_rst_r   <= 1'b1;
      io_default_r <= 1'b1;
    end else if (clk_en) begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      core_rst_r   <= core_rst_nxt;
      io_default_r <= io_default_nxt;
    end
  end

  // ==========================================================
  // core multiplier: straps during reset, software write afterwards
  logic [5:0] core_mult_nxt;
  logic [5:0] strap_mult;

  always_comb begin
    case (sel_r)
      core_clk_rst_pkg::SEL_16TO1: strap_mult = core_clk_rst_pkg::MULT_16;
      core_clk_rst_pkg::SEL_8TO1:  strap_mult = core_clk_rst_pkg::MULT_8;
      default:                     strap_mult = core_clk_rst_pkg::MULT_3;
    endcase
    core_mult_nxt = core_mult_r;
    if (state_r != core_clk_rst_pkg::ST_RUN) begin
      core_mult_nxt = strap_mult;
    end else if (pll_mult_wr && pll_mult_in != 6'h00) begin
      core_mult_nxt = pll_mult_in;  // range is software's to
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      core_mult_r <= core_clk_rst_pkg::MULT_DEFAULT;
    end else if (clk_en) begin
      core_mult_r <= core_mult_nxt;
    end
  end

  // ==========================================================
  // serial port clocks: per-port phase accumulator in core cycles.
  // one tick per input cycle at most, so dividers below the
  // multiplier saturate at the input rate
  wire logic [NPORTS-1:0] sport_tick_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi++) begin : g_port
      logic [16:0] acc_r, acc_nxt;
      logic        tick_nxt;
      logic [16:0] sum;
      logic [16:0] div;
      always_comb begin
        div      = {1'b0, serial_port_divider[gi*16 +: 16]};
        sum      = acc_r + {11'h000, core_mult_r};
        acc_nxt  = sum;
        tick_nxt = 1'b0;
        if (core_rst_r || div == 17'h00000) begin
          acc_nxt = 17'h00000;
        end else if (sum >= div) begin
          acc_nxt  = (sum - div >= div) ? 17'h00000 : sum - div;
          tick_nxt = 1'b1;
        end
      end
      assign sport_tick_nxt[gi] = tick_nxt;
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          acc_r <= 17'h00000;
        end else if (clk_en) begin
          acc_r <= acc_nxt;
        end
      end
    end
  endgenerate

  // one register for all ticks, so the output has a single driving process
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sport_tick_r <= '0;
    end else if (clk_en) begin
      sport_tick_r <= sport_tick_nxt;
    end
  end

  // ==========================================================
  // checks
  core_rst_pin_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && pin_low_r |=> core_rst_r) else $error("core reset not held with pin low");
  hold_full_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(core_rst_r) |-> cnt_r == 13'(core_clk_rst_pkg::CORE_RST_CYC))
    else $error("core reset released at wrong count");
  hold_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cnt_r <= 13'(core_clk_rst_pkg::CORE_RST_MAX)) else $error("release count overran");
  count_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && state_r == core_clk_rst_pkg::ST_HOLD && !pin_low_r |=> state_r == core_clk_rst_pkg::ST_COUNT)
    else $error("count did not start on release");
  io_default_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && pin_low_r |=> io_default_r) else $error("pins not at default during reset");
  strap_ratio_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && pin_low_r && state_r == core_clk_rst_pkg::ST_HOLD && sel_r == core_clk_rst_pkg::SEL_16TO1
    |=> core_mult_r == core_clk_rst_pkg::MULT_16)
    else $error("strap ratio not applied");
  sw_ratio_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && state_r == core_clk_rst_pkg::ST_RUN && pll_mult_wr && pll_mult_in != 6'h00 |=> core_mult_r == $past(pll_mult_in))
    else $error("software ratio not taken");
  sport_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    core_rst_r && clk_en |=> sport_tick_r == '0) else $error("serial clock ran in reset");
endmodule : core_clock_reset_sequencer

// file: bench/board_rst_model.sv
// board reset source model: reset pin with minimum low widths and ratio straps
`timescale 1ns/1ps
module board_rst_model (
  input  wire logic       sys_clk,
  input  wire logic       hold_req,
  input  wire logic [1:0] strap_val,
  output logic            ext_rst_n,
  output logic [1:0]      ratio_select_pins
);
  localparam int FIRST_LOW = core_clk_rst_pkg::PLL_SETUP_CYC;
  localparam int LATER_LOW = core_clk_rst_pkg::MIN_PULSE_CYC;
  logic pin_r   = 1'b0;
  logic first_r = 1'b1;
  logic req_r   = 1'b1;
  int   low_cnt = 0;
  // straps are static board levels, stable across the whole reset
  assign ratio_select_pins = strap_val;
  assign ext_rst_n         = pin_r;
  // ==========================================================
  // pin driver
  // request taken at the edge, pin moved 1 ns later like every other bench input
  // first release after 1000 low cycles: clock settled and pll inputs set up
  // later pulses never shorter than 4 input cycles, even if asked for less
  // the bench clock stands for a running oscillator, so no crystal start-up wait
  // bench cycles count only as input cycles; straps 01 and 10 assume a slower clock
  always @(posedge sys_clk) begin
    req_r = hold_req;
    #1;
    if (req_r) begin
      pin_r = 1'b0;
    end else if (!pin_r && low_cnt >= (first_r ? FIRST_LOW : LATER_LOW)) begin
      pin_r   = 1'b1;
      first_r = 1'b0;
      low_cnt = 0;
    end
    if (!pin_r && low_cnt < FIRST_LOW) begin
      low_cnt = low_cnt + 1;  // saturates, so a long hold cannot wrap
    end
  end
endmodule : board_rst_model

// file: bench/tb_top.sv
// self-checking bench for the core clock and reset sequencer
`timescale 1ns/1ps
module tb_top;
  // one extra edge for the board model to pick up the request
  localparam int LO = core_clk_rst_pkg::CORE_RST_CYC + 1;
  localparam int HI = core_clk_rst_pkg::CORE_RST_MAX + 1;
  logic        sys_clk = 1'b0;
  logic        clk_en = 1'b1;
  logic        sys_rst = 1'b1;
  logic        hold_req = 1'b1;
  logic [1:0]  strap_val = 2'h0;
  logic        pll_mult_wr = 1'b0;
  logic [5:0]  pll_mult_in = 6'h00;
  logic [63:0] serial_port_divider = 64'h0;
  logic        ext_rst_n;
  logic [1:0]  ratio_select_pins;
  logic [5:0]  core_mult_r;
  logic        core_rst_r;
  logic        io_default_r;
  logic [3:0]  sport_tick_r;
  int          miscompares = 0;
  int          compares = 0;
  int          n;
  int          t0;
  int          t1;
  int          t2;
  logic [1:0]  row_strap [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [5:0]  row_mult [4] = '{core_clk_rst_pkg::MULT_3, core_clk_rst_pkg::MULT_16,
                                 core_clk_rst_pkg::MULT_8, core_clk_rst_pkg::MULT_DEFAULT};
  always #10 sys_clk = ~sys_clk;
  board_rst_model board_rst_model_inst (.sys_clk(sys_clk), .hold_req(hold_req), .strap_val(strap_val),
    .ext_rst_n(ext_rst_n), .ratio_select_pins(ratio_select_pins));
  core_clock_reset_sequencer core_clock_reset_sequencer_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .ext_rst_n(ext_rst_n), .ratio_select_pins(ratio_select_pins), .pll_mult_wr(pll_mult_wr),
    .pll_mult_in(pll_mult_in), .serial_port_divider(serial_port_divider), .core_mult_r(core_mult_r),
    .core_rst_r(core_rst_r), .io_default_r(io_default_r), .sport_tick_r(sport_tick_r));
  // ==========================================================
  // helpers
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic check_range(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr_mult(input logic [5:0] v);
    pll_mult_wr = 1'b1;
    pll_mult_in = v;
    cyc(1);
    pll_mult_wr = 1'b0;
    cyc(2);
  endtask : wr_mult
  // bounded wait; a hang here ends the run as a failure
  task automatic release_count;
    hold_req = 1'b0;
    n = 0;
    while (core_rst_r !== 1'b0 && n < 5000) begin
      cyc(1);
      n++;
    end
    if (n == 5000) begin
      miscompares++;
      end_sim();
    end
  endtask : release_count
  // ==========================================================
  // main sequence
  initial begin
    cyc(12);
    sys_rst = 1'b0;
    cyc(1100);
    // one row per strap code; a write while held in reset must be ignored
    for (int i = 0; i < 4; i++) begin
      hold_req = 1'b1;
      strap_val = row_strap[i];
      cyc(core_clk_rst_pkg::PLL_SETUP_CYC);
      check(io_default_r, 1'b1);
      wr_mult(6'h05);
      check(core_rst_r, 1'b1);
      release_count();
      check_range(n, LO, HI);
      strap_val = ~row_strap[i];
      cyc(4);
      check(core_mult_r, row_mult[i]);
      check(io_default_r, 1'b0);
    end
    // software ratio once out of reset, 4 keeps a 5 ns core period; zero is refused
    wr_mult(6'h04);
    check(core_mult_r, 6'h04);
    wr_mult(6'h00);
    check(core_mult_r, 6'h04);
    // multiplier 4: port 0 (divider 10) ticks 2 in 5, port 2 (divider 4) every cycle, 1 and 3 off
    serial_port_divider = {16'h0000, 16'h0004, 16'h0000, 16'h000A};
    cyc(10);
    t0 = 0;
    t1 = 0;
    t2 = 0;
    repeat (40) begin
      cyc(1);
      t0 += int'(sport_tick_r[0]);
      t1 += int'(sport_tick_r[1]) + int'(sport_tick_r[3]);
      t2 += int'(sport_tick_r[2]);
    end
    check(t0[15:0], 16'h0010);
    check(t1[15:0], 16'h0000);
    check(t2[15:0], 16'h0028);
    // reassert mid-count: the release count starts over from zero
    hold_req = 1'b1;
    cyc(8);
    hold_req = 1'b0;
    cyc(2000);
    check(core_rst_r, 1'b1);
    hold_req = 1'b1;
    cyc(6);
    release_count();
    check_range(n, LO, HI);
    // clock enable low freezes all state: a reassertion is seen only once it returns
    clk_en = 1'b0;
    hold_req = 1'b1;
    cyc(10);
    check(core_rst_r, 1'b0);
    clk_en = 1'b1;
    cyc(6);
    check(core_rst_r, 1'b1);
    release_count();
    check_range(n, LO, HI);
    end_sim();
  end
endmodule : tb_top
